// ### core/act_pkg.sv
// Constants, register map and state type of the converter correction and thermal block
package act_pkg;
  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam longint CLK_HZ = 250000000;
  localparam longint FAST_RATE_SPS = 160000;
  localparam longint SLOW_RATE_MILLI_SPS = 898876;
  localparam int FAST_CYCLES = int'(CLK_HZ / FAST_RATE_SPS);
  localparam int SLOW_CYCLES = int'((CLK_HZ * 1000) / SLOW_RATE_MILLI_SPS);
  // --------------------------------------------------------------------------
  // Register byte addresses
  // --------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CONV_CFG = 8'h00;
  localparam logic [7:0] ADDR_FE_CFG = 8'h04;
  localparam logic [7:0] ADDR_FILT_CFG = 8'h08;
  localparam logic [7:0] ADDR_RAW = 8'h0c;
  localparam logic [7:0] ADDR_GAIN0 = 8'h10;
  localparam logic [7:0] ADDR_OFFS0 = 8'h1c;
  localparam logic [7:0] ADDR_TRIM = 8'h28;
  localparam logic [7:0] ADDR_UGAIN = 8'h2c;
  localparam logic [7:0] ADDR_UOFFS = 8'h30;
  localparam logic [7:0] ADDR_TRES = 8'h34;
  localparam logic [7:0] ADDR_STATUS = 8'h38;
  localparam logic [7:0] ADDR_STREAM = 8'h3c;
  localparam logic [7:0] ADDR_FILT_RES = 8'h40;
  // --------------------------------------------------------------------------
  // Fields
  // --------------------------------------------------------------------------
  localparam int MUX_LSB = 0;
  localparam int PAIR_LSB = 5;
  localparam int EXCITE_BIT = 7;
  localparam int ADC_EN_BIT = 7;
  localparam int TSENS_EN_BIT = 12;
  localparam int TCONV_EN_BIT = 13;
  localparam int CONV_EN_BIT = 14;
  localparam int FILT_EN_BIT = 15;
  localparam int BYPASS_BIT = 0;
  localparam int READY_BIT = 3;
  localparam logic [4:0] MUX_TEMP = 5'h03;
  localparam int NUM_PAIRS = 3;
  localparam int GAIN_FRAC = 14;
  localparam logic [16:0] CODE_MID = 17'h08000;
  // --------------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------------
  localparam logic [15:0] GAIN_ONE = 16'h4000;
  localparam logic [15:0] OFFS_ZERO = 16'h0000;
  localparam logic [15:0] TRIM_RESET = 16'h4000;
  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [7:0] conv_cfg;
    logic [15:0] fe_cfg;
    logic bypass;
    logic [NUM_PAIRS-1:0][15:0] gain;
    logic [NUM_PAIRS-1:0][15:0] offs;
    logic [15:0] trim;
    logic [15:0] ugain;
    logic [15:0] uoffs;
    logic [15:0] raw;
    logic [15:0] stream_word;
    logic stream_valid;
    logic [15:0] slow_word;
    logic slow_valid;
    logic [10:0] fast_cnt;
    logic [18:0] slow_cnt;
    logic [15:0] t1;
    logic t1_valid;
    logic [15:0] tres;
    logic ready;
  } act_state_type;
endpackage : act_pkg

// ### core/act_core.sv
// Converter gain/offset correction, output taps, excitation switch and thermal conversion
//
// Design decisions made here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
module act_core #(
  parameter int SLOW_CYCLES = act_pkg::SLOW_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hibernate_i,
  input wire logic [7:0] avs_address_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [15:0] adc_sample_i,
  input wire logic [15:0] high_rate_sinc_output_i,
  input wire logic [15:0] low_rate_sinc_output_i,
  output logic [15:0] stream_word_o,
  output logic stream_valid_o,
  output logic [15:0] slow_word_o,
  output logic slow_valid_o,
  output logic [4:0] mux_select_o,
  output logic temp_route_o,
  output logic excitation_switch_o,
  output logic adc_power_o,
  output logic temp_sensor_power_o
);
  act_pkg::act_state_type s_q;
  act_pkg::act_state_type s_d;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Byte-lane merge for Avalon writes
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction : merge16

  // Unsigned word times Q2.14 gain plus signed offset, clamped to the 16-bit code range
  function automatic logic [15:0] correct(input logic [15:0] raw, input logic [15:0] g, input logic [15:0] o);
    logic [32:0] prod;
    logic signed [19:0] sum;
    prod = {17'h00000, raw} * {17'h00000, g};
    sum = signed'({1'b0, prod[32:act_pkg::GAIN_FRAC]}) + 20'(signed'(o));
    if (sum < 20'sh00000) begin
      return 16'h0000;
    end else if (sum > 20'sh0ffff) begin
      return 16'hffff;
    end
    return sum[15:0];
  endfunction : correct

  // --------------------------------------------------------------------------
  // Control decode
  // --------------------------------------------------------------------------
  logic running;
  logic fast_tick;
  logic slow_tick;
  logic [1:0] pair;
  logic [1:0] pair_idx;
  logic [15:0] corrected;
  logic [15:0] temp_code;
  logic temp_sample;
  logic hit_gain;
  logic hit_offs;
  logic [1:0] reg_idx;
  logic [31:0] rd_mux;

  // Conversion runs while the converter is powered and enabled
  assign running = s_q.fe_cfg[act_pkg::ADC_EN_BIT] & s_q.fe_cfg[act_pkg::CONV_EN_BIT];
  // The fast divider drops the half cycle of the ideal period, so this tap runs a hair fast
  assign fast_tick = running && (s_q.fast_cnt == 11'(act_pkg::FAST_CYCLES - 1));
  assign slow_tick = running && (s_q.slow_cnt == 19'(SLOW_CYCLES - 1));
  assign pair = s_q.conv_cfg[act_pkg::PAIR_LSB +: 2];
  // Reserved pair code falls back to the first pair rather than reading out of range
  assign pair_idx = (pair == 2'd3) ? 2'd0 : pair;
  assign corrected = correct(adc_sample_i, s_q.gain[pair_idx], s_q.offs[pair_idx]);

  // Thermal source: corrected stream, high-rate sinc or low-rate sinc
  always_comb begin
    if (!s_q.fe_cfg[act_pkg::FILT_EN_BIT]) begin
      temp_code = corrected;
      temp_sample = fast_tick;
    end else if (s_q.bypass) begin
      temp_code = high_rate_sinc_output_i;
      temp_sample = fast_tick;
    end else begin
      temp_code = low_rate_sinc_output_i;
      temp_sample = slow_tick;
    end
  end

  // Register index decode for the correction pair banks
  always_comb begin
    hit_gain = 1'b0;
    hit_offs = 1'b0;
    reg_idx = 2'd0;
    for (int i = 0; i < act_pkg::NUM_PAIRS; i++) begin
      if (avs_address_i == act_pkg::ADDR_GAIN0 + 8'(4 * i)) begin
        hit_gain = 1'b1;
        reg_idx = 2'(i);
      end
      if (avs_address_i == act_pkg::ADDR_OFFS0 + 8'(4 * i)) begin
        hit_offs = 1'b1;
        reg_idx = 2'(i);
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read multiplexer
  // --------------------------------------------------------------------------
  // Unmapped addresses read as zero
  always_comb begin
    rd_mux = 32'h00000000;
    if (hit_gain) begin
      rd_mux = {16'h0000, s_q.gain[reg_idx]};
    end else if (hit_offs) begin
      rd_mux = {16'h0000, s_q.offs[reg_idx]};
    end else begin
      unique case (avs_address_i)
        act_pkg::ADDR_CONV_CFG: rd_mux = {24'h000000, s_q.conv_cfg};
        act_pkg::ADDR_FE_CFG: rd_mux = {16'h0000, s_q.fe_cfg};
        act_pkg::ADDR_FILT_CFG: rd_mux = {31'h00000000, s_q.bypass};
        act_pkg::ADDR_RAW: rd_mux = {16'h0000, s_q.raw};
        act_pkg::ADDR_TRIM: rd_mux = {16'h0000, s_q.trim};
        act_pkg::ADDR_UGAIN: rd_mux = {16'h0000, s_q.ugain};
        act_pkg::ADDR_UOFFS: rd_mux = {16'h0000, s_q.uoffs};
        act_pkg::ADDR_TRES: rd_mux = {16'h0000, s_q.tres};
        act_pkg::ADDR_STATUS: rd_mux = 32'(s_q.ready) << act_pkg::READY_BIT;
        act_pkg::ADDR_STREAM: rd_mux = {16'h0000, s_q.stream_word};
        act_pkg::ADDR_FILT_RES: rd_mux = {16'h0000, s_q.slow_word};
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic wr;
    logic signed [16:0] centred;
    logic signed [33:0] p1;
    logic signed [33:0] p2;
    logic signed [33:0] sum2;
    s_d = s_q;
    wr = avs_write_i & s_q.ack;
    centred = 17'sh00000;
    p1 = 34'sh000000000;
    p2 = 34'sh000000000;
    sum2 = 34'sh000000000;
    // Bus handshake: one wait cycle, then the access completes on the ack cycle
    // A request still standing after its ack cycle starts a fresh access
    s_d.ack = (avs_read_i | avs_write_i) & ~s_q.ack;
    if (avs_read_i & ~s_q.ack) begin
      s_d.rdata = rd_mux;
    end
    // Configuration writes
    if (wr) begin
      if (hit_gain) begin
        s_d.gain[reg_idx] = merge16(s_q.gain[reg_idx], avs_writedata_i, avs_byteenable_i);
      end
      if (hit_offs) begin
        s_d.offs[reg_idx] = merge16(s_q.offs[reg_idx], avs_writedata_i, avs_byteenable_i);
      end
      if (avs_address_i == act_pkg::ADDR_CONV_CFG && avs_byteenable_i[0]) begin
        s_d.conv_cfg = avs_writedata_i[7:0];
      end
      if (avs_address_i == act_pkg::ADDR_FE_CFG) begin
        s_d.fe_cfg = merge16(s_q.fe_cfg, avs_writedata_i, avs_byteenable_i);
      end
      if (avs_address_i == act_pkg::ADDR_FILT_CFG && avs_byteenable_i[0]) begin
        s_d.bypass = avs_writedata_i[act_pkg::BYPASS_BIT];
      end
      if (avs_address_i == act_pkg::ADDR_TRIM) begin
        s_d.trim = merge16(s_q.trim, avs_writedata_i, avs_byteenable_i);
      end
      if (avs_address_i == act_pkg::ADDR_UGAIN) begin
        s_d.ugain = merge16(s_q.ugain, avs_writedata_i, avs_byteenable_i);
      end
      if (avs_address_i == act_pkg::ADDR_UOFFS) begin
        s_d.uoffs = merge16(s_q.uoffs, avs_writedata_i, avs_byteenable_i);
      end
      // Write one to clear; a coinciding new result is applied below and wins
      if (avs_address_i == act_pkg::ADDR_STATUS && avs_byteenable_i[0] && avs_writedata_i[act_pkg::READY_BIT]) begin
        s_d.ready = 1'b0;
      end
    end
    // Hibernate drops the correction banks back to unity gain and zero offset
    if (hibernate_i) begin
      for (int i = 0; i < act_pkg::NUM_PAIRS; i++) begin
        s_d.gain[i] = act_pkg::GAIN_ONE;
        s_d.offs[i] = act_pkg::OFFS_ZERO;
      end
    end
    // Rate dividers restart whenever conversion stops
    s_d.stream_valid = 1'b0;
    s_d.slow_valid = 1'b0;
    if (!running) begin
      s_d.fast_cnt = 11'h000;
      s_d.slow_cnt = 19'h00000;
    end else begin
      s_d.fast_cnt = fast_tick ? 11'h000 : s_q.fast_cnt + 11'h001;
      s_d.slow_cnt = slow_tick ? 19'h00000 : s_q.slow_cnt + 19'h00001;
    end
    // Corrected 160 kSPS tap and raw result
    if (fast_tick) begin
      s_d.raw = adc_sample_i;
      s_d.stream_word = corrected;
      s_d.stream_valid = 1'b1;
    end
    // Low-rate tap after the supply rejection filter
    if (slow_tick) begin
      s_d.slow_word = low_rate_sinc_output_i;
      s_d.slow_valid = 1'b1;
    end
    // Thermal stage one: factory scaling of the centred code
    s_d.t1_valid = 1'b0;
    if (temp_sample && s_q.fe_cfg[act_pkg::TCONV_EN_BIT] && temp_route_o) begin
      centred = signed'({1'b0, temp_code}) - signed'(act_pkg::CODE_MID);
      // Both factors are widened first, so the product keeps every bit
      // whatever width the multiply would take on its own
      p1 = 34'(centred) * 34'(signed'({1'b0, s_q.trim}));
      s_d.t1 = 16'(p1 >>> act_pkg::GAIN_FRAC);
      s_d.t1_valid = 1'b1;
    end
    // Thermal stage two: user gain and offset, then store and flag
    if (s_q.t1_valid) begin
      // User gain is unsigned Q2.14, so it gets a zero top bit before widening
      p2 = 34'(signed'(s_q.t1)) * 34'(signed'({1'b0, s_q.ugain}));
      // The result wraps rather than saturates: software sees the low 16 bits
      sum2 = (p2 >>> act_pkg::GAIN_FRAC) + 34'(signed'(s_q.uoffs));
      s_d.tres = sum2[15:0];
      s_d.ready = 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      for (int i = 0; i < act_pkg::NUM_PAIRS; i++) begin
        s_q.gain[i] <= act_pkg::GAIN_ONE;
        s_q.offs[i] <= act_pkg::OFFS_ZERO;
      end
      s_q.trim <= act_pkg::TRIM_RESET;
      s_q.ugain <= act_pkg::GAIN_ONE;
      s_q.uoffs <= act_pkg::OFFS_ZERO;
    end else begin
      s_q <= s_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~s_q.ack;
  assign avs_readdata_o = s_q.rdata;
  assign stream_word_o = s_q.stream_word;
  assign stream_valid_o = s_q.stream_valid;
  assign slow_word_o = s_q.slow_word;
  assign slow_valid_o = s_q.slow_valid;
  assign mux_select_o = s_q.conv_cfg[act_pkg::MUX_LSB +: 5];
  assign temp_route_o = (s_q.conv_cfg[act_pkg::MUX_LSB +: 5] == act_pkg::MUX_TEMP);
  // Reference only reaches the pin while the switch bit is set
  assign excitation_switch_o = s_q.conv_cfg[act_pkg::EXCITE_BIT];
  assign adc_power_o = s_q.fe_cfg[act_pkg::ADC_EN_BIT];
  assign temp_sensor_power_o = s_q.fe_cfg[act_pkg::TSENS_EN_BIT];
endmodule : act_core

// ### tb/act_core_checker.sv
// Port checker for the converter correction and thermal block
`timescale 1ns/1ps
module act_core_checker #(
  parameter int SLOW_CYCLES = 40
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hibernate_i,
  input wire logic [7:0] avs_address_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic stream_valid_o,
  input wire logic slow_valid_o,
  input wire logic [4:0] mux_select_o,
  input wire logic temp_route_o,
  input wire logic excitation_switch_o,
  input wire logic adc_power_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic [19:0] fgap_q;
  logic [19:0] sgap_q;
  logic ex_wd;
  logic [4:0] mux_wd;
  // Write-data slices, so that the past of each field can be taken
  assign ex_wd = avs_writedata_i[act_pkg::EXCITE_BIT];
  assign mux_wd = avs_writedata_i[act_pkg::MUX_LSB +: 5];
  // Cycles since the last tap pulse; a tap that comes early shows a wrong divider
  always_ff @(posedge clk_i) begin
    fgap_q <= (rst_i || stream_valid_o) ? 20'h0 : fgap_q + 20'h1;
    sgap_q <= (rst_i || slow_valid_o) ? 20'h0 : sgap_q + 20'h1;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence s_cfg_wr;
    avs_write_i && !avs_waitrequest_o && avs_address_i == act_pkg::ADDR_CONV_CFG && avs_byteenable_i[0];
  endsequence
  sequence s_hib_rd;
    hibernate_i ##1 (hibernate_i && avs_read_i && avs_waitrequest_o && avs_address_i == act_pkg::ADDR_GAIN0);
  endsequence
  property p_excite; s_cfg_wr |=> excitation_switch_o == $past(ex_wd); endproperty
  a_excite: assert property (p_excite) else $error("excitation switch misses config write");
  property p_mux; s_cfg_wr |=> mux_select_o == $past(mux_wd); endproperty
  a_mux: assert property (p_mux) else $error("selector misses config write");
  property p_route; s_cfg_wr |=> temp_route_o == ($past(mux_wd) == act_pkg::MUX_TEMP); endproperty
  a_route: assert property (p_route) else $error("sensor route disagrees with written selector");
  property p_hib; s_hib_rd ##1 !avs_waitrequest_o |-> avs_readdata_o[15:0] == act_pkg::GAIN_ONE; endproperty
  a_hib: assert property (p_hib) else $error("gain kept during hibernate");
  property p_wait; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
  a_wait: assert property (p_wait) else $error("access not answered after one wait cycle");
  property p_pulse; stream_valid_o |=> !stream_valid_o; endproperty
  a_pulse: assert property (p_pulse) else $error("stream valid longer than one cycle");
  property p_fgap; stream_valid_o |-> fgap_q >= 20'(act_pkg::FAST_CYCLES - 1); endproperty
  a_fgap: assert property (p_fgap) else $error("stream word faster than fast rate");
  property p_sgap; slow_valid_o |-> sgap_q >= 20'(SLOW_CYCLES - 1); endproperty
  a_sgap: assert property (p_sgap) else $error("slow word faster than slow rate");
  property p_power; stream_valid_o |-> adc_power_o; endproperty
  a_power: assert property (p_power) else $error("stream word while converter disabled");
endmodule : act_core_checker

bind act_core act_core_checker #(.SLOW_CYCLES(SLOW_CYCLES)) act_core_checker_inst (.*);

// ### tb/act_core_tb_top.sv
// Self-checking bench for the converter correction and thermal block
`timescale 1ns/1ps
module act_core_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hib = 1'b0;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wait_o;
  logic [15:0] smp = 16'h0;
  logic [15:0] lf = 16'h0;
  logic [15:0] hf = 16'h0;
  logic [15:0] sword;
  logic svalid;
  logic slowv;
  logic exc;
  logic [4:0] msel;
  logic [15:0] slw;
  logic tpow;
  int fail_count = 0;
  int checks_done = 0;
  logic [31:0] rq[$];
  logic [15:0] sq[$];
  // 250 MHz clock
  always #2 clk_i = ~clk_i;
  act_core #(.SLOW_CYCLES(40)) act_core_inst (.clk_i(clk_i), .rst_i(rst_i), .hibernate_i(hib),
    .avs_address_i(addr), .avs_byteenable_i(4'hf), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o), .adc_sample_i(smp), .high_rate_sinc_output_i(hf),
    .low_rate_sinc_output_i(lf), .stream_word_o(sword), .stream_valid_o(svalid), .slow_word_o(slw),
    .slow_valid_o(slowv), .mux_select_o(msel), .temp_route_o(), .excitation_switch_o(exc), .adc_power_o(),
    .temp_sensor_power_o(tpow));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One bus access; the request stands until the rising edge at which waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk_i);
    while (wait_o !== 1'b0) @(posedge clk_i);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic rd_exp(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd_exp
  task automatic wait_v(input logic slow);
    @(negedge clk_i);
    while ((slow ? slowv : svalid) !== 1'b1) @(negedge clk_i);
  endtask : wait_v
  function automatic logic [15:0] corr(input logic [15:0] s, input logic [15:0] g, input logic [15:0] o);
    longint v;
    v = ((longint'(s) * longint'(g)) >>> 14) + longint'($signed(o));
    return (v < 0) ? 16'h0 : (v > 65535) ? 16'hffff : v[15:0];
  endfunction : corr
  function automatic logic [15:0] therm(input logic [15:0] c, input logic [15:0] t, input logic [15:0] ug,
    input logic [15:0] uo);
    longint d;
    logic signed [15:0] t1;
    d = ((longint'(c) - 32768) * longint'(t)) >>> 14;
    t1 = d[15:0];
    d = ((longint'(t1) * longint'(ug)) >>> 14) + longint'($signed(uo));
    return d[15:0];
  endfunction : therm
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // Result watchers: the oldest note is compared when a result shows
  // Read data is taken at the same rising edge at which the master sees waitrequest low
  always @(posedge clk_i) begin
    if (rd === 1'b1 && wait_o === 1'b0 && rq.size() > 0) chk("read data", rq.pop_front(), rdata);
  end
  always @(negedge clk_i) begin
    if (svalid === 1'b1 && sq.size() > 0) chk("stream word", {16'h0, sq.pop_front()}, {16'h0, sword});
  end
  // Watchdog, well past the expected run of some 20400 cycles
  initial begin
    #240000;
    fail_count++;
    summarize();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] g, o, s;
    void'($urandom(36));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      rd_exp(act_pkg::ADDR_GAIN0 + 8'(4 * i), 32'h4000);
      rd_exp(act_pkg::ADDR_OFFS0 + 8'(4 * i), 32'h0);
    end
    rd_exp(act_pkg::ADDR_TRIM, 32'h4000);
    rd_exp(8'h44, 32'h0);
    $display("test reset_values done");
    // Close the switch, let it settle, steer the selector, then start conversion and filter
    bus(1'b1, act_pkg::ADDR_CONV_CFG, 32'h80);
    @(negedge clk_i);
    chk("excitation", 32'h1, {31'h0, exc});
    repeat (25) @(posedge clk_i);
    bus(1'b1, act_pkg::ADDR_CONV_CFG, 32'h8c);
    repeat (25) @(posedge clk_i);
    bus(1'b1, act_pkg::ADDR_FE_CFG, 32'hc080);
    @(negedge clk_i);
    chk("selector", 32'h0c, {27'h0, msel});
    bus(1'b1, act_pkg::ADDR_CONV_CFG, 32'h00);
    @(negedge clk_i);
    chk("excitation", 32'h0, {31'h0, exc});
    $display("test excitation done");
    // Random gain, offset and sample on each pair in turn; clamping is hit at random
    bus(1'b1, act_pkg::ADDR_FE_CFG, 32'h4080);
    wait_v(1'b0);
    for (int k = 0; k < 6; k++) begin
      g = 16'($urandom);
      o = 16'($urandom);
      s = 16'($urandom);
      bus(1'b1, act_pkg::ADDR_GAIN0 + 8'(4 * (k % 3)), {16'h0, g});
      bus(1'b1, act_pkg::ADDR_OFFS0 + 8'(4 * (k % 3)), {16'h0, o});
      bus(1'b1, act_pkg::ADDR_CONV_CFG, 32'(k % 3) << 5);
      smp <= s;
      sq.push_back(corr(s, g, o));
      wait_v(1'b0);
      rd_exp(act_pkg::ADDR_RAW, {16'h0, s});
    end
    $display("test correction done");
    hib <= 1'b1;
    rd_exp(act_pkg::ADDR_GAIN0, 32'h4000);
    rd_exp(act_pkg::ADDR_OFFS0 + 8'h4, 32'h0);
    hib <= 1'b0;
    rd_exp(act_pkg::ADDR_GAIN0 + 8'h8, 32'h4000);
    // Correction words are lost in hibernate, so software loads unity and zero again
    bus(1'b1, act_pkg::ADDR_GAIN0, 32'h4000);
    bus(1'b1, act_pkg::ADDR_OFFS0, 32'h0);
    $display("test hibernate done");
    // Thermal path fed from the corrected stream, pair 0 now neutral
    bus(1'b1, act_pkg::ADDR_CONV_CFG, 32'h02);
    bus(1'b1, act_pkg::ADDR_FE_CFG, 32'h7080);
    bus(1'b1, act_pkg::ADDR_TRIM, 32'h2000);
    bus(1'b1, act_pkg::ADDR_UGAIN, 32'h6000);
    bus(1'b1, act_pkg::ADDR_UOFFS, 32'hfff0);
    smp <= 16'h9d1e;
    wait_v(1'b0);
    wait_v(1'b0);
    chk("sensor power", 32'h1, {31'h0, tpow});
    rd_exp(act_pkg::ADDR_STATUS, 32'h0);
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, act_pkg::ADDR_CONV_CFG, 32'h00);
      bus(1'b1, act_pkg::ADDR_CONV_CFG, 32'h03);
      wait_v(1'b0);
      rd_exp(act_pkg::ADDR_STATUS, 32'h8);
      rd_exp(act_pkg::ADDR_TRES, {16'h0, therm(smp, 16'h2000, 16'h6000, 16'hfff0)});
      bus(1'b1, act_pkg::ADDR_STATUS, 32'h8);
      rd_exp(act_pkg::ADDR_STATUS, 32'h0);
      bus(1'b1, act_pkg::ADDR_CONV_CFG, 32'h00);
      rd_exp(act_pkg::ADDR_TRES, {16'h0, therm(smp, 16'h2000, 16'h6000, 16'hfff0)});
      smp <= 16'($urandom);
    end
    $display("test thermal done");
    lf <= 16'($urandom);
    wait_v(1'b1);
    wait_v(1'b1);
    chk("slow word", {16'h0, lf}, {16'h0, slw});
    rd_exp(act_pkg::ADDR_FILT_RES, {16'h0, lf});
    $display("test slow_tap done");
    // Thermal source from the low-rate sinc, then from the high-rate sinc in bypass
    bus(1'b1, act_pkg::ADDR_FE_CFG, 32'hf080);
    for (int m = 0; m < 2; m++) begin
      s = 16'($urandom);
      lf <= s;
      hf <= ~s;
      bus(1'b1, act_pkg::ADDR_FILT_CFG, 32'(m));
      bus(1'b1, act_pkg::ADDR_CONV_CFG, 32'h03);
      // The second pulse is sure to come from a tick that saw the new selector
      wait_v(m == 0);
      wait_v(m == 0);
      rd_exp(act_pkg::ADDR_TRES, {16'h0, therm((m == 0) ? s : ~s, 16'h2000, 16'h6000, 16'hfff0)});
      bus(1'b1, act_pkg::ADDR_CONV_CFG, 32'h00);
    end
    $display("test thermal_source done");
    chk("stream notes left", 32'h0, sq.size());
    summarize();
  end
endmodule : act_core_tb_top
